// ### hdl/dcm_regs.svh
// Offsets, fields, codes and reset values of the comm register map
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH

// Register offsets
`define DCM_OFS_FREQ_SETPOINT     16'h2001
`define DCM_OFS_DRIVE_CTRL        16'h2002
`define DCM_OFS_FAULT_CODE        16'h2100
`define DCM_OFS_FREQ_READBACK     16'h2102
`define DCM_OFS_OUT_FREQ          16'h2103
`define DCM_OFS_OUT_CURRENT       16'h2104
`define DCM_OFS_DC_BUS            16'h2105
`define DCM_OFS_OUT_VOLTAGE       16'h2106
`define DCM_OFS_STEP_INDEX        16'h2107
`define DCM_OFS_MULTI_DISPLAY     16'h2116
`define DCM_OFS_STATUS_WORD       16'h2119
`define DCM_OFS_ANALOG_ONE        16'h2201
`define DCM_OFS_DOUT_STATE        16'h2209

// Control word fields
`define DCM_CTRL_FAULT_BIT        0
`define DCM_CTRL_RESET_BIT        1
`define DCM_CTRL_BASE_BLOCK_BIT   2

// Status word fields
`define DCM_ST_RUN_LSB            0
`define DCM_ST_RUN_MSB            1
`define DCM_ST_JOG_BIT            2
`define DCM_ST_DIR_LSB            3
`define DCM_ST_DIR_MSB            4
`define DCM_ST_FREQ_COMM_BIT      8
`define DCM_ST_FREQ_TERM_BIT      9
`define DCM_ST_RUN_COMM_BIT       10
`define DCM_ST_LOCK_BIT           11
`define DCM_ST_COPY_BIT           12

// Direction codes in the status word
`define DCM_DIR_SAME              2'h0
`define DCM_DIR_OUT_INV           2'h1
`define DCM_DIR_CMD_INV           2'h2

// Function codes and exception marker
`define DCM_FC_READ               8'h03
`define DCM_FC_WRITE              8'h06
`define DCM_FC_EXC_MASK           8'h80

// Exception codes
`define DCM_EXC_DATA_RANGE        8'h01
`define DCM_EXC_BAD_ADDR          8'h02
`define DCM_EXC_PWD_LOCK          8'h03
`define DCM_EXC_IN_OPERATION      8'h04
`define DCM_EXC_TIMEOUT           8'h0A

// Decimal split of a display code
`define DCM_DEC_TEN               8'h0A

// Reset values
`define DCM_RST_WORD              16'h0000
`define DCM_RST_BYTE              8'h00

`endif

// ### hdl/dcm_pkg.sv
// Types shared by the comm register map modules
package dcm_pkg;

   // Kind of location behind an address
   typedef enum logic [1:0] {
      DCM_ACC_NONE,
      DCM_ACC_RO,
      DCM_ACC_WO
   } dcm_acc_t;

   // State of the register core
   typedef struct packed {
      logic [15:0] freq_set;
      logic        fault_in;
      logic        base_block;
      logic        fault_reset;
      logic        rsp_valid;
      logic        rsp_exc;
      logic [7:0]  rsp_func;
      logic [15:0] rsp_addr;
      logic [15:0] rsp_data;
      logic [7:0]  disp_code;
      logic        disp_valid;
   } dcm_core_t;

   // State of the status packer
   typedef struct packed {
      logic [15:0] word;
   } dcm_pack_t;

endpackage

// ### hdl/dcm_stat_if.sv
// Drive condition bits for the status word packer
`timescale 1ns/1ps
`default_nettype none

interface dcm_stat_if;
   logic [1:0]  run_state;
   logic        jog_active;
   logic        cmd_reverse;
   logic        out_reverse;
   logic        freq_src_comm;
   logic        freq_src_terminal;
   logic        run_src_comm;
   logic        param_lock;
   logic        copy_enable;
   logic [15:0] status_word;

   modport core (
      output run_state, jog_active, cmd_reverse, out_reverse, freq_src_comm,
             freq_src_terminal, run_src_comm, param_lock, copy_enable,
      input  status_word
   );

   modport pack (
      input  run_state, jog_active, cmd_reverse, out_reverse, freq_src_comm,
             freq_src_terminal, run_src_comm, param_lock, copy_enable,
      output status_word
   );
endinterface

`default_nettype wire

// ### hdl/dcm_status_pack.sv
// Registered packing of the drive status word
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.svh"

module dcm_status_pack (
   input  wire logic mclk_i,
   input  wire logic srst_i,
   dcm_stat_if.pack  stat
);

   dcm_pkg::dcm_pack_t st_q;
   dcm_pkg::dcm_pack_t st_d;

   // Reserved bits stay zero as the word starts from zero
   always_comb
   begin
      st_d      = st_q;
      st_d.word = `DCM_RST_WORD;
      st_d.word[`DCM_ST_RUN_MSB:`DCM_ST_RUN_LSB] = stat.run_state;
      st_d.word[`DCM_ST_JOG_BIT] = stat.jog_active;
      // Reverse/reverse has no code, so it reads as matching
      if (!stat.cmd_reverse && stat.out_reverse)
      begin
         st_d.word[`DCM_ST_DIR_MSB:`DCM_ST_DIR_LSB] = `DCM_DIR_OUT_INV;
      end
      else if (stat.cmd_reverse && !stat.out_reverse)
      begin
         st_d.word[`DCM_ST_DIR_MSB:`DCM_ST_DIR_LSB] = `DCM_DIR_CMD_INV;
      end
      else
      begin
         st_d.word[`DCM_ST_DIR_MSB:`DCM_ST_DIR_LSB] = `DCM_DIR_SAME;
      end
      st_d.word[`DCM_ST_FREQ_COMM_BIT] = stat.freq_src_comm;
      st_d.word[`DCM_ST_FREQ_TERM_BIT] = stat.freq_src_terminal;
      st_d.word[`DCM_ST_RUN_COMM_BIT]  = stat.run_src_comm;
      st_d.word[`DCM_ST_LOCK_BIT]      = stat.param_lock;
      st_d.word[`DCM_ST_COPY_BIT]      = stat.copy_enable;
   end

   // Register the packed word
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         st_q.word <= `DCM_RST_WORD;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign stat.status_word = st_q.word;

endmodule // dcm_status_pack

`default_nettype wire

// ### hdl/dcm_regmap.sv
// Serial comm register map of the drive: request decode, replies, exceptions
//
// What this block does
// - Control word bit 0 sets external fault, bit 1 pulses fault reset, bit 2 sets base block.
// - Status bits 0-1 give the run state and bit 2 is set while an inching command is active.
// - Status bits 3-4 code commanded against actual direction as 00, 01 or 10, never 11.
// - Status bit 8 marks a frequency reference from the comm interface.
// - Status bit 9 marks a frequency reference from the terminal source.
// - Status bit 10 marks run and stop commands from the comm source.
// - Status bit 11 shows a parameter lock, bit 12 shows keypad copy enabled, bits 13-15 are zero.
// - A read-only location returns the multi-step speed number now selected.
// - A read-only location returns analog input one as a percentage with two decimals.
// - A request damaged by a comm error gets no reply at all.
// - A clean request that cannot be carried out gets an exception reply.
// - An exception reply echoes the function code with its top bit set and carries the cause code.
// - Each exception shows a keypad code whose two decimal digits equal the exception code.
// - Exception codes are 1 data range, 2 bad address, 3 password lock, 10 time-out; code 4 busy running is never raised.
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.svh"

module dcm_regmap #(
   parameter logic [15:0] FREQ_MAX = 16'hFFFF   // Highest accepted frequency setpoint
) (
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // Request from the frame layer
   input  wire logic        req_valid_i,
   input  wire logic        req_frame_ok_i,
   input  wire logic        req_timeout_i,
   input  wire logic [7:0]  req_func_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [15:0] req_data_i,
   // Reply to the frame layer
   output logic             rsp_valid_o,
   output logic             rsp_exc_o,
   output logic [7:0]       rsp_func_o,
   output logic [15:0]      rsp_addr_o,
   output logic [15:0]      rsp_data_o,
   // Keypad error display
   output logic             comm_error_display_valid_o,
   output logic [7:0]       comm_error_display_code_o,
   // Commands toward the drive
   output logic [15:0]      freq_setpoint_o,
   output logic             external_fault_flag_o,
   output logic             fault_reset_o,
   output logic             base_block_o,
   // Drive conditions
   input  wire logic [1:0]  run_state_i,
   input  wire logic        jog_active_i,
   input  wire logic        cmd_reverse_direction_i,
   input  wire logic        out_reverse_direction_i,
   input  wire logic        freq_src_comm_i,
   input  wire logic        freq_src_terminal_i,
   input  wire logic        comm_operation_source_i,
   input  wire logic        param_lock_i,
   input  wire logic        copy_enable_i,
   input  wire logic        run_active_i,
   // Monitor values
   input  wire logic [15:0] fault_code_i,
   input  wire logic [15:0] freq_readback_i,
   input  wire logic [15:0] output_frequency_i,
   input  wire logic [15:0] output_current_i,
   input  wire logic [15:0] dc_bus_voltage_i,
   input  wire logic [15:0] output_voltage_i,
   input  wire logic [15:0] speed_step_index_i,
   input  wire logic [15:0] multi_function_display_i,
   input  wire logic [15:0] analog_input_one_i,
   input  wire logic [15:0] digital_output_state_i
);

   dcm_pkg::dcm_core_t core_q;
   dcm_pkg::dcm_core_t core_d;
   dcm_stat_if         stat ();

   // Classify an address; read and write paths both go through this
   function automatic dcm_pkg::dcm_acc_t dcm_decode(input logic [15:0] addr);
      dcm_pkg::dcm_acc_t acc;
      acc = dcm_pkg::DCM_ACC_NONE;
      case (addr)
         `DCM_OFS_FREQ_SETPOINT,
         `DCM_OFS_DRIVE_CTRL:     acc = dcm_pkg::DCM_ACC_WO;
         `DCM_OFS_FAULT_CODE,
         `DCM_OFS_FREQ_READBACK,
         `DCM_OFS_OUT_FREQ,
         `DCM_OFS_OUT_CURRENT,
         `DCM_OFS_DC_BUS,
         `DCM_OFS_OUT_VOLTAGE,
         `DCM_OFS_STEP_INDEX,
         `DCM_OFS_MULTI_DISPLAY,
         `DCM_OFS_STATUS_WORD,
         `DCM_OFS_ANALOG_ONE,
         `DCM_OFS_DOUT_STATE:     acc = dcm_pkg::DCM_ACC_RO;
         default:                 acc = dcm_pkg::DCM_ACC_NONE;
      endcase
      return acc;
   endfunction

   // Split an exception code into two decimal digits for the keypad
   function automatic logic [7:0] dcm_to_decimal(input logic [7:0] code);
      logic [7:0] tens;
      logic [7:0] ones;
      tens = code / `DCM_DEC_TEN;
      ones = code % `DCM_DEC_TEN;
      return {tens[3:0], ones[3:0]};
   endfunction

   // Drive conditions feed the status packer straight from the ports
   assign stat.run_state         = run_state_i;
   assign stat.jog_active        = jog_active_i;
   assign stat.cmd_reverse       = cmd_reverse_direction_i;
   assign stat.out_reverse       = out_reverse_direction_i;
   assign stat.freq_src_comm     = freq_src_comm_i;
   assign stat.freq_src_terminal = freq_src_terminal_i;
   assign stat.run_src_comm      = comm_operation_source_i;
   assign stat.param_lock        = param_lock_i;
   assign stat.copy_enable       = copy_enable_i;

   dcm_status_pack u_pack (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .stat   (stat)
   );

   // Request handling: one request per cycle, reply one cycle later
   always_comb
   begin
      dcm_pkg::dcm_acc_t acc;
      logic              fail;
      logic [7:0]        exc;
      logic [15:0]       rdata;
      acc   = dcm_decode(req_addr_i);
      fail  = 1'b0;
      exc   = `DCM_RST_BYTE;
      rdata = `DCM_RST_WORD;
      core_d = core_q;
      // Pulses and reply strobe last one cycle only
      core_d.fault_reset = 1'b0;
      core_d.rsp_valid   = 1'b0;
      core_d.disp_valid  = 1'b0;

      // Read data selection
      case (req_addr_i)
         `DCM_OFS_FAULT_CODE:     rdata = fault_code_i;
         `DCM_OFS_FREQ_READBACK:  rdata = freq_readback_i;
         `DCM_OFS_OUT_FREQ:       rdata = output_frequency_i;
         `DCM_OFS_OUT_CURRENT:    rdata = output_current_i;
         `DCM_OFS_DC_BUS:         rdata = dc_bus_voltage_i;
         `DCM_OFS_OUT_VOLTAGE:    rdata = output_voltage_i;
         `DCM_OFS_STEP_INDEX:     rdata = speed_step_index_i;
         `DCM_OFS_MULTI_DISPLAY:  rdata = multi_function_display_i;
         `DCM_OFS_STATUS_WORD:    rdata = stat.status_word;
         `DCM_OFS_ANALOG_ONE:     rdata = analog_input_one_i;
         `DCM_OFS_DOUT_STATE:     rdata = digital_output_state_i;
         default:                 rdata = `DCM_RST_WORD;
      endcase

      // A damaged frame is dropped silently; the master times out on its own
      if (req_valid_i && req_frame_ok_i)
      begin
         if (req_timeout_i)
         begin
            fail = 1'b1;
            exc  = `DCM_EXC_TIMEOUT;
         end
         else if (req_func_i == `DCM_FC_READ)
         begin
            if (acc != dcm_pkg::DCM_ACC_RO)
            begin
               fail = 1'b1;
               exc  = `DCM_EXC_BAD_ADDR;
            end
         end
         else if (req_func_i == `DCM_FC_WRITE)
         begin
            if (acc != dcm_pkg::DCM_ACC_WO)
            begin
               fail = 1'b1;
               exc  = `DCM_EXC_BAD_ADDR;
            end
            else if (req_addr_i == `DCM_OFS_FREQ_SETPOINT && param_lock_i)
            begin
               fail = 1'b1;
               exc  = `DCM_EXC_PWD_LOCK;
            end
            else if (req_addr_i == `DCM_OFS_FREQ_SETPOINT && req_data_i > FREQ_MAX)
            begin
               fail = 1'b1;
               exc  = `DCM_EXC_DATA_RANGE;
            end
         end
         else
         begin
            // Unknown function: the content cannot be recognised
            fail = 1'b1;
            exc  = `DCM_EXC_DATA_RANGE;
         end

         // Writes take effect only when the request is accepted
         if (!fail && req_func_i == `DCM_FC_WRITE)
         begin
            if (req_addr_i == `DCM_OFS_FREQ_SETPOINT)
            begin
               core_d.freq_set = req_data_i;
            end
            else
            begin
               // Reserved bits 3-15 are dropped
               core_d.fault_in    = req_data_i[`DCM_CTRL_FAULT_BIT];
               core_d.fault_reset = req_data_i[`DCM_CTRL_RESET_BIT];
               core_d.base_block  = req_data_i[`DCM_CTRL_BASE_BLOCK_BIT];
            end
         end

         // Reply: normal echo or exception in place of it
         core_d.rsp_valid = 1'b1;
         core_d.rsp_addr  = req_addr_i;
         if (fail)
         begin
            core_d.rsp_exc    = 1'b1;
            core_d.rsp_func   = req_func_i | `DCM_FC_EXC_MASK;
            core_d.rsp_data   = {8'h00, exc};
            core_d.disp_code  = dcm_to_decimal(exc);
            core_d.disp_valid = 1'b1;
         end
         else
         begin
            core_d.rsp_exc  = 1'b0;
            core_d.rsp_func = req_func_i;
            core_d.rsp_data = (req_func_i == `DCM_FC_READ) ? rdata : req_data_i;
         end
      end
   end

   // Register all core state
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         core_q.freq_set    <= `DCM_RST_WORD;
         core_q.fault_in    <= 1'b0;
         core_q.base_block  <= 1'b0;
         core_q.fault_reset <= 1'b0;
         core_q.rsp_valid   <= 1'b0;
         core_q.rsp_exc     <= 1'b0;
         core_q.rsp_func    <= `DCM_RST_BYTE;
         core_q.rsp_addr    <= `DCM_RST_WORD;
         core_q.rsp_data    <= `DCM_RST_WORD;
         core_q.disp_code   <= `DCM_RST_BYTE;
         core_q.disp_valid  <= 1'b0;
      end
      else
      begin
         core_q <= core_d;
      end
   end

   // Outputs straight from the state register
   assign rsp_valid_o                = core_q.rsp_valid;
   assign rsp_exc_o                  = core_q.rsp_exc;
   assign rsp_func_o                 = core_q.rsp_func;
   assign rsp_addr_o                 = core_q.rsp_addr;
   assign rsp_data_o                 = core_q.rsp_data;
   assign comm_error_display_valid_o = core_q.disp_valid;
   assign comm_error_display_code_o  = core_q.disp_code; // Held until the next exception
   assign freq_setpoint_o            = core_q.freq_set;
   assign external_fault_flag_o      = core_q.fault_in;
   assign fault_reset_o              = core_q.fault_reset;
   assign base_block_o               = core_q.base_block;

endmodule // dcm_regmap

`default_nettype wire

// ### dv/dcm_regmap_assertions.sv
// Port checks of the comm register map
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.svh"

module dcm_regmap_assertions (
   input wire logic        mclk_i,
   input wire logic        srst_i,
   input wire logic        req_valid_i,
   input wire logic        req_frame_ok_i,
   input wire logic        req_timeout_i,
   input wire logic [7:0]  req_func_i,
   input wire logic [15:0] req_addr_i,
   input wire logic [15:0] req_data_i,
   input wire logic [15:0] speed_step_index_i,
   input wire logic        rsp_valid_o,
   input wire logic        rsp_exc_o,
   input wire logic [7:0]  rsp_func_o,
   input wire logic [15:0] rsp_data_o,
   input wire logic        comm_error_display_valid_o,
   input wire logic [7:0]  comm_error_display_code_o,
   input wire logic [15:0] freq_setpoint_o,
   input wire logic        external_fault_flag_o,
   input wire logic        fault_reset_o,
   input wire logic        base_block_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   // Clean requests; a timed-out frame is never taken
   logic take;
   logic wr_ctrl;
   logic wr_freq;
   assign take    = req_valid_i && req_frame_ok_i && !req_timeout_i;
   assign wr_ctrl = take && req_func_i == `DCM_FC_WRITE && req_addr_i == `DCM_OFS_DRIVE_CTRL;
   assign wr_freq = take && req_func_i == `DCM_FC_WRITE && req_addr_i == `DCM_OFS_FREQ_SETPOINT;

   chk_reply_next: assert property (req_valid_i && req_frame_ok_i |=> rsp_valid_o)
      else $error("clean request got no reply");
   chk_drop_damaged: assert property (req_valid_i && !req_frame_ok_i |=> !rsp_valid_o)
      else $error("damaged request got a reply");
   chk_exc_func: assert property (rsp_valid_o && rsp_exc_o |-> rsp_func_o == ($past(req_func_i) | 8'h80))
      else $error("exception function code wrong");
   chk_timeout_code: assert property (req_valid_i && req_frame_ok_i && req_timeout_i
      |=> rsp_exc_o && rsp_data_o == 16'h000A && comm_error_display_code_o == 8'h10)
      else $error("time-out exception code wrong");
   chk_disp_pair: assert property ((rsp_valid_o && rsp_exc_o) == comm_error_display_valid_o
      && (!comm_error_display_valid_o || comm_error_display_code_o ==
      ((rsp_data_o[7:0] == 8'h0A) ? 8'h10 : rsp_data_o[7:0])))
      else $error("keypad code wrong");
   chk_ctrl_apply: assert property (wr_ctrl |=> {base_block_o, fault_reset_o, external_fault_flag_o}
      == $past(req_data_i[2:0]))
      else $error("control bits not applied");
   chk_flag_hold: assert property (!wr_ctrl |=> !fault_reset_o &&
      $stable({external_fault_flag_o, base_block_o}))
      else $error("control outputs moved");
   chk_status_rsvd: assert property (take && req_func_i == `DCM_FC_READ &&
      req_addr_i == `DCM_OFS_STATUS_WORD |=> rsp_data_o[15:13] == 3'h0 &&
      rsp_data_o[7:5] == 3'h0 && rsp_data_o[4:3] != 2'h3)
      else $error("status word reserved field set");
   chk_step_read: assert property (take && req_func_i == `DCM_FC_READ &&
      req_addr_i == `DCM_OFS_STEP_INDEX |=> !rsp_exc_o && rsp_data_o == $past(speed_step_index_i))
      else $error("step index read wrong");
   chk_freq_hold: assert property ($changed(freq_setpoint_o) |-> $past(wr_freq))
      else $error("setpoint changed unasked");
endmodule // dcm_regmap_assertions

bind dcm_regmap dcm_regmap_assertions u_chk (.mclk_i, .srst_i, .req_valid_i, .req_frame_ok_i,
   .req_timeout_i, .req_func_i, .req_addr_i, .req_data_i, .speed_step_index_i, .rsp_valid_o,
   .rsp_exc_o, .rsp_func_o, .rsp_data_o, .comm_error_display_valid_o, .comm_error_display_code_o,
   .freq_setpoint_o, .external_fault_flag_o, .fault_reset_o, .base_block_o);

`default_nettype wire

// ### dv/dcm_master_model.sv
// Serial bus master issuing decoded requests
`timescale 1ns/1ps
`default_nettype none

module dcm_master_model #(
   parameter int REPLY_LIMIT = 8   // Reply wait limit in cycles
) (
   input  wire logic        mclk_i,
   input  wire logic        rsp_valid_i,
   output logic             req_valid_o,
   output logic             req_frame_ok_o,
   output logic             req_timeout_o,
   output logic [7:0]       req_func_o,
   output logic [15:0]      req_addr_o,
   output logic [15:0]      req_data_o,
   output logic             no_reply_o
);
   int pend_q = 0;
   int age_q  = 0;

   initial
   begin
      {req_valid_o, req_frame_ok_o, req_timeout_o, no_reply_o} = 4'h0;
      {req_func_o, req_addr_o, req_data_o} = 40'h0;
   end

   // One request per call; back-to-back calls keep the strobe high
   task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                       input logic ok, input logic tmo);
      @(posedge mclk_i);
      req_valid_o    <= 1'b1;
      req_frame_ok_o <= ok;
      req_timeout_o  <= tmo;
      req_func_o     <= f;
      req_addr_o     <= a;
      req_data_o     <= d;
   endtask

   // Released fields are scrambled so nothing can lean on stale values
   task automatic idle();
      @(posedge mclk_i);
      req_valid_o <= 1'b0;
      req_func_o  <= ~req_func_o;
      req_addr_o  <= ~req_addr_o;
      req_data_o  <= ~req_data_o;
   endtask

   // Own reply time-out: a dropped frame must never hang the master
   always @(posedge mclk_i)
   begin
      pend_q     <= pend_q + int'(req_valid_o && req_frame_ok_o) - int'(rsp_valid_i === 1'b1);
      age_q      <= (pend_q == 0 || rsp_valid_i === 1'b1) ? 0 : age_q + 1;
      no_reply_o <= (age_q > REPLY_LIMIT);
   end
endmodule // dcm_master_model

`default_nettype wire

// ### dv/drive_comm_control_status_map_tb.sv
// Self-checking bench of the comm register map
`timescale 1ns/1ps
`default_nettype none
`include "dcm_regs.svh"

module drive_comm_control_status_map_tb;
   localparam logic [15:0] FMAX = 16'h1000;
   localparam logic [15:0] RO_ADDR [10] = '{`DCM_OFS_FAULT_CODE, `DCM_OFS_FREQ_READBACK,
      `DCM_OFS_OUT_FREQ, `DCM_OFS_OUT_CURRENT, `DCM_OFS_DC_BUS, `DCM_OFS_OUT_VOLTAGE,
      `DCM_OFS_STEP_INDEX, `DCM_OFS_MULTI_DISPLAY, `DCM_OFS_ANALOG_ONE, `DCM_OFS_DOUT_STATE};
   typedef struct packed {
      logic exc; logic dv; logic [7:0] func; logic [15:0] addr; logic [15:0] data;
      logic [7:0] disp; logic flt; logic bb; logic fr; logic [15:0] freq;
   } dcm_tb_exp_t;

   logic        mclk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [10:0] cond;
   logic [15:0] mon [10];
   logic        req_valid, req_ok, req_tmo, no_reply;
   logic [7:0]  req_func, rsp_func, disp_code;
   logic [15:0] req_addr, req_data, rsp_addr, rsp_data, freq_set, d;
   logic        rsp_valid, rsp_exc, disp_valid, flt, fr, bb, flt_m, bb_m;
   logic [15:0] freq_m;
   dcm_tb_exp_t exp_q [$];
   int          bad_count = 0;
   int          n_checks  = 0;

   always #10 mclk_i = ~mclk_i;

   dcm_master_model u_master (.mclk_i(mclk_i), .rsp_valid_i(rsp_valid), .req_valid_o(req_valid),
      .req_frame_ok_o(req_ok), .req_timeout_o(req_tmo), .req_func_o(req_func),
      .req_addr_o(req_addr), .req_data_o(req_data), .no_reply_o(no_reply));

   dcm_regmap #(.FREQ_MAX(FMAX)) u_dcm_regmap (.mclk_i(mclk_i), .srst_i(srst_i),
      .req_valid_i(req_valid), .req_frame_ok_i(req_ok), .req_timeout_i(req_tmo),
      .req_func_i(req_func), .req_addr_i(req_addr), .req_data_i(req_data),
      .rsp_valid_o(rsp_valid), .rsp_exc_o(rsp_exc), .rsp_func_o(rsp_func), .rsp_addr_o(rsp_addr),
      .rsp_data_o(rsp_data), .comm_error_display_valid_o(disp_valid),
      .comm_error_display_code_o(disp_code), .freq_setpoint_o(freq_set),
      .external_fault_flag_o(flt), .fault_reset_o(fr), .base_block_o(bb),
      .run_state_i(cond[1:0]), .jog_active_i(cond[2]), .out_reverse_direction_i(cond[3]),
      .cmd_reverse_direction_i(cond[4]), .freq_src_comm_i(cond[5]), .freq_src_terminal_i(cond[6]),
      .comm_operation_source_i(cond[7]), .param_lock_i(cond[8]), .copy_enable_i(cond[9]),
      .run_active_i(cond[10]), .fault_code_i(mon[0]), .freq_readback_i(mon[1]),
      .output_frequency_i(mon[2]), .output_current_i(mon[3]), .dc_bus_voltage_i(mon[4]),
      .output_voltage_i(mon[5]), .speed_step_index_i(mon[6]), .multi_function_display_i(mon[7]),
      .analog_input_one_i(mon[8]), .digital_output_state_i(mon[9]));

   task automatic fail(input string m);
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Reverse/reverse reads as 00
   function automatic logic [15:0] stat_exp();
      logic [1:0] dir;
      dir = (cond[4:3] == 2'h3) ? 2'h0 : cond[4:3];
      return {3'h0, cond[9:5], 3'h0, dir, cond[2:0]};
   endfunction

   // Issue a request, queue its reply
   task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] dd,
                      input logic ok = 1'b1, input logic tmo = 1'b0);
      dcm_tb_exp_t e;
      logic [7:0]  c;
      u_master.send(f, a, dd, ok, tmo);
      e = '0;
      e.func = f;
      e.addr = a;
      e.data = dd;
      c = 8'h00;
      if (tmo)
         c = `DCM_EXC_TIMEOUT;
      else if (f == `DCM_FC_READ)
      begin
         c = `DCM_EXC_BAD_ADDR;
         if (a == `DCM_OFS_STATUS_WORD)
         begin
            c = 8'h00;
            e.data = stat_exp();
         end
         foreach (RO_ADDR[i])
            if (a == RO_ADDR[i])
            begin
               c = 8'h00;
               e.data = mon[i];
            end
      end
      else if (f == `DCM_FC_WRITE)
      begin
         if (a == `DCM_OFS_FREQ_SETPOINT)
            c = cond[8] ? `DCM_EXC_PWD_LOCK : ((dd > FMAX) ? `DCM_EXC_DATA_RANGE : 8'h00);
         else if (a != `DCM_OFS_DRIVE_CTRL)
            c = `DCM_EXC_BAD_ADDR;
      end
      else
         c = `DCM_EXC_DATA_RANGE;
      if (ok && c == 8'h00 && f == `DCM_FC_WRITE)
      begin
         if (a == `DCM_OFS_FREQ_SETPOINT)
            freq_m = dd;
         else
         begin
            flt_m = dd[0];
            bb_m = dd[2];
            e.fr = dd[1];
         end
      end
      if (c != 8'h00)
      begin
         e.exc  = 1'b1;
         e.dv   = 1'b1;
         e.func = f | 8'h80;
         e.data = {8'h00, c};
         e.disp = ((c / 8'h0A) << 4) | (c % 8'h0A);
      end
      e.flt  = flt_m;
      e.bb   = bb_m;
      e.freq = freq_m;
      if (ok)
         exp_q.push_back(e);
   endtask

   // New conditions settle through the status register
   task automatic set_cond(input logic [10:0] v);
      u_master.idle();
      cond <= v;
      u_master.idle();
      u_master.idle();
   endtask

   // Oldest note against each reply, at the falling edge
   always @(negedge mclk_i)
   begin
      dcm_tb_exp_t g;
      if (no_reply === 1'b1)
         fail("reply time-out");
      if (!srst_i && rsp_valid === 1'b1)
      begin
         n_checks++;
         g = {rsp_exc, disp_valid, rsp_func, rsp_addr, rsp_data, rsp_exc ? disp_code : 8'h00,
              flt, bb, fr, freq_set};
         if (exp_q.size() == 0)
            fail("reply without a clean request");
         else if (g !== exp_q.pop_front())
            fail("reply mismatch");
      end
      else if (!srst_i && (disp_valid !== 1'b0 || fr !== 1'b0))
         fail("pulse without a reply");
   end

   initial
   begin
      void'($urandom(32'hDC35978D));
      cond   = 11'h000;
      flt_m  = 1'b0;
      bb_m   = 1'b0;
      freq_m = 16'h0000;
      foreach (mon[i]) mon[i] = 16'h0000;
      repeat (3) @(posedge mclk_i);
      srst_i <= 1'b0;
      // Control writes back to back, reserved bits random
      for (int i = 0; i < 8; i++)
      begin
         d = 16'($urandom);
         d[2:0] = i[2:0];
         req(`DCM_FC_WRITE, `DCM_OFS_DRIVE_CTRL, d);
      end
      req(`DCM_FC_WRITE, `DCM_OFS_DRIVE_CTRL, 16'h0007, 1'b0);
      req(`DCM_FC_WRITE, `DCM_OFS_FREQ_SETPOINT, FMAX);
      req(`DCM_FC_WRITE, `DCM_OFS_FREQ_SETPOINT, FMAX + 16'h0001);
      req(`DCM_FC_WRITE, `DCM_OFS_DRIVE_CTRL, 16'h0007, 1'b1, 1'b1);
      req(`DCM_FC_READ, 16'h9999, 16'h0000);
      req(`DCM_FC_WRITE, `DCM_OFS_FAULT_CODE, 16'h0001);
      req(`DCM_FC_READ, `DCM_OFS_FREQ_SETPOINT, 16'h0000);
      req(8'h10, `DCM_OFS_DRIVE_CTRL, 16'h0001);
      set_cond(11'h100);
      req(`DCM_FC_WRITE, `DCM_OFS_FREQ_SETPOINT, 16'h0001);
      // Status word, corner then random conditions
      for (int i = 0; i < 10; i++)
      begin
         set_cond(i == 0 ? 11'h7FF : 11'($urandom));
         req(`DCM_FC_READ, `DCM_OFS_STATUS_WORD, 16'h0000);
      end
      u_master.idle();
      foreach (mon[i]) mon[i] <= 16'($urandom);
      foreach (RO_ADDR[i]) req(`DCM_FC_READ, RO_ADDR[i], 16'h0000);
      u_master.idle();
      for (int k = 0; k < 16 && exp_q.size() != 0; k++) @(posedge mclk_i);
      if (exp_q.size() != 0)
         fail("replies missing");
      end_sim();
   end
endmodule // drive_comm_control_status_map_tb

`default_nettype wire
